// [bench/smets_cpu_model.sv]
// Processor-side model that decodes which management request line is asserted
`timescale 1ns/10ps
module smets_cpu_model
  import smets_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic active_low,
  input wire logic sys_mgmt_irq,
  input wire logic nmi_req,
  input wire logic irq15_req,
  input wire logic irq10_req,
  output logic [3:0] seen,
  output logic [7:0] entries
);
  logic smi_act;
  logic any_reg;

  // Dedicated line polarity depends on the convention the processor expects
  assign smi_act = active_low ? ~sys_mgmt_irq : sys_mgmt_irq;
  // One line per route: dedicated, non-maskable, irq15, irq10
  assign seen = {irq10_req, irq15_req, nmi_req, smi_act};

  // Count an entry when any request rises from all lines idle; a stuck line shows as no new entry
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      any_reg <= 1'b0;
      entries <= 8'h00;
    end else begin
      any_reg <= |seen;
      if (|seen && !any_reg) begin
        entries <= entries + 8'h01;
      end
    end
  end
endmodule

// [bench/smets_top_test.sv]
// Self-checking bench for the management-interrupt event block
`timescale 1ns/10ps
module smets_top_test
  import smets_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  smets_events_type events = '0;
  logic [15:0] irq_lines = 16'h0000;
  logic nmi_in = 1'b0, switch_lvl = 1'b0, turbo_lvl = 1'b0, cpu_low = 1'b0;
  logic sys_mgmt_irq, nmi_req, irq15_req, irq10_req, double_time_base, int_out;
  logic [3:0] cpu_seen;
  int fail_count = 0;
  int n_compared = 0;

  smets_top dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .events(events), .irq_lines(irq_lines), .nmi_in(nmi_in),
    .suspend_switch_input(switch_lvl), .sys_mgmt_irq(sys_mgmt_irq), .nmi_req(nmi_req),
    .irq15_req(irq15_req), .irq10_req(irq10_req),
    .double_time_base(double_time_base), .int_out(int_out)
  );

  smets_cpu_model cpu (
    .aclk(aclk), .aresetn(aresetn), .active_low(cpu_low), .sys_mgmt_irq(sys_mgmt_irq),
    .nmi_req(nmi_req), .irq15_req(irq15_req), .irq10_req(irq10_req),
    .seen(cpu_seen), .entries()
  );

  // 50 ns period
  always #25 aclk = ~aclk;

  // ----------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------
  task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic print_verdict();
    $display("Counts: %0d compared, %0d mismatched", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic give_up(input string what);
    fail_count++;
    $display("[FAIL] %s expected handshake seen none", what);
    print_verdict();
  endtask

  // ----------------------------------------------------------------
  // Bus tasks: byte address is four times the index
  // ----------------------------------------------------------------
  task automatic axi_wr(input logic [7:0] idx, input logic [31:0] data, input logic [1:0] exp);
    int n;
    @(posedge aclk);
    awaddr <= {2'b00, idx, 2'b00};
    wdata <= data;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        bready <= 1'b0;
        check_val("bresp", {30'h0, exp}, {30'h0, bresp});
        break;
      end
    end
    if (n == 50) give_up("write");
  endtask

  task automatic axi_rd(input logic [7:0] idx, input logic [1:0] exp, output logic [31:0] d);
    int n;
    @(posedge aclk);
    araddr <= {2'b00, idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        rready <= 1'b0;
        d = rdata;
        check_val("rresp", {30'h0, exp}, {30'h0, rresp});
        break;
      end
    end
    if (n == 50) give_up("read");
  endtask

  task automatic rd_chk(input string what, input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    axi_rd(idx, RESP_OKAY, d);
    check_val(what, exp, d);
  endtask

  task automatic expect_cause(input logic [3:0] code);
    logic [31:0] d;
    axi_rd(IDX_STATUS, RESP_OKAY, d);
    check_val("cause", {28'h0, code}, d & 32'h0000_000F);
  endtask

  task automatic service();
    axi_wr(IDX_CONTROL, 32'h2, RESP_OKAY);
  endtask

  // ----------------------------------------------------------------
  // Event stimulus: turbo is a level, so the idle value keeps its state
  // ----------------------------------------------------------------
  task automatic pulse(input smets_events_type e, input logic [15:0] irq, input logic nmi);
    @(posedge aclk);
    events <= e;
    irq_lines <= irq;
    nmi_in <= nmi;
    @(posedge aclk);
    e = '0;
    e.turbo_status = turbo_lvl;
    events <= e;
    irq_lines <= 16'h0000;
    nmi_in <= 1'b0;
  endtask

  task automatic sw(input logic lvl);
    @(posedge aclk);
    switch_lvl <= lvl;
  endtask

  task automatic fire(input int code);
    smets_events_type e;
    e = '0;
    if (code == 15) turbo_lvl = ~turbo_lvl;
    e.turbo_status = turbo_lvl;
    case (code)
      1: e.mode_timer = 1'b1;
      2: e.input_timer = 1'b1;
      3: e.gmem_timer = 1'b1;
      4: e.rtc_alarm = 1'b1;
      5: e.input_activity = 1'b1;
      7: e.drq_activity = 1'b1;
      9, 10, 11, 12, 13: e.trap_access[code-9] = 1'b1;
      14: axi_wr(IDX_CONTROL, 32'h1, RESP_OKAY);
      default: ;
    endcase
    if (code != 14) pulse(e, (code == 6) ? 16'h0001 : 16'h0000, 1'b0);
    if (code == 8) sw(~switch_lvl);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    smets_events_type e;
    int i;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk("status reset", IDX_STATUS, 32'h0);
    rd_chk("group reset", IDX_IRQ_GRP, 32'h0);
    check_val("smi idle", 32'h0, {31'h0, sys_mgmt_irq});
    axi_wr(IDX_IRQ_GRP, 32'hFF, RESP_OKAY);
    rd_chk("group bits", IDX_IRQ_GRP, 32'hE5);
    axi_wr(IDX_STATUS, 32'h0F, RESP_OKAY);
    rd_chk("cause read-only", IDX_STATUS, 32'h0);
    axi_wr(8'h20, 32'h1, RESP_SLVERR);
    rd_chk("control reads zero", IDX_CONTROL, 32'h0);
    axi_wr(IDX_TRAP_SEL, 32'h80, RESP_OKAY);
    check_val("double base", 32'h1, {31'h0, double_time_base});
    $display("Test registers done");
    // Every cause code, one at a time, on the dedicated line
    axi_wr(IDX_TRIG_SEL, 32'hFF, RESP_OKAY);
    axi_wr(IDX_TRAP_SEL, 32'h3F, RESP_OKAY);
    axi_wr(IDX_IRQ_GRP, 32'h01, RESP_OKAY);
    rd_chk("trap sel", IDX_TRAP_SEL, 32'h3F);
    check_val("double base off", 32'h0, {31'h0, double_time_base});
    for (i = 1; i < 16; i++) begin
      fire(i);
      expect_cause(i[3:0]);
      check_val("smi route", 32'h1, {28'h0, cpu_seen});
      service();
      expect_cause(CAUSE_NONE);
    end
    $display("Test cause codes done");
    // Two events together, lowest code first then the other
    e = '0;
    e.turbo_status = turbo_lvl;
    e.mode_timer = 1'b1;
    e.trap_access[4] = 1'b1;
    pulse(e, 16'h0000, 1'b0);
    expect_cause(4'h1);
    service();
    expect_cause(4'hD);
    service();
    expect_cause(CAUSE_NONE);
    $display("Test priority done");
    // Disabled events are dropped
    axi_wr(IDX_TRIG_SEL, 32'h00, RESP_OKAY);
    axi_wr(IDX_TRAP_SEL, 32'h00, RESP_OKAY);
    fire(1);
    fire(9);
    axi_wr(IDX_TRIG_SEL, 32'hFF, RESP_OKAY);
    expect_cause(CAUSE_NONE);
    // Switch edges; the input is high here
    axi_wr(IDX_TRAP_SEL, 32'h40, RESP_OKAY);
    sw(1'b0);
    expect_cause(CAUSE_SWITCH);
    service();
    sw(1'b1);
    expect_cause(CAUSE_NONE);
    axi_wr(IDX_TRAP_SEL, 32'h20, RESP_OKAY);
    sw(1'b0);
    expect_cause(CAUSE_NONE);
    sw(1'b1);
    expect_cause(CAUSE_SWITCH);
    service();
    axi_wr(IDX_TRIG_SEL, 32'h7F, RESP_OKAY);
    axi_wr(IDX_TRAP_SEL, 32'h60, RESP_OKAY);
    sw(1'b0);
    expect_cause(CAUSE_NONE);
    $display("Test switch done");
    // Group membership: input-device channels never count
    axi_wr(IDX_IRQ_GRP, 32'hFF, RESP_OKAY);
    pulse(events, 16'h101A, 1'b0);
    expect_cause(CAUSE_NONE);
    axi_wr(IDX_IRQ_GRP, 32'h04, RESP_OKAY);
    pulse(events, 16'h00E1, 1'b1);
    expect_cause(4'h6);
    service();
    axi_wr(IDX_IRQ_GRP, 32'h00, RESP_OKAY);
    pulse(events, 16'h00E1, 1'b1);
    expect_cause(CAUSE_NONE);
    $display("Test group done");
    // Each route once, each with a different convention code
    for (i = 0; i < 4; i++) begin
      axi_wr(IDX_STATUS, i * 32'h50, RESP_OKAY);
      cpu_low = (i == 1);
      fire(14);
      rd_chk("status", IDX_STATUS, i * 32'h50 + 32'hE);
      check_val("route", 32'h1 << i, {28'h0, cpu_seen});
      service();
      check_val("route idle", 32'h0, {28'h0, cpu_seen});
    end
    axi_wr(IDX_STATUS, 32'h40, RESP_OKAY);
    check_val("low idle", 32'h1, {31'h0, sys_mgmt_irq});
    fire(14);
    expect_cause(CAUSE_SOFTWARE);
    check_val("low active", 32'h0, {31'h0, sys_mgmt_irq});
    service();
    axi_wr(IDX_STATUS, 32'h00, RESP_OKAY);
    cpu_low = 1'b0;
    $display("Test routing done");
    // Interrupt status, mask and clear
    axi_wr(IDX_INT_STAT, 32'h3, RESP_OKAY);
    axi_wr(IDX_INT_MASK, 32'h0, RESP_OKAY);
    fire(1);
    rd_chk("int stat", IDX_INT_STAT, 32'h1);
    check_val("int masked", 32'h0, {31'h0, int_out});
    axi_wr(IDX_INT_MASK, 32'h1, RESP_OKAY);
    check_val("int unmasked", 32'h1, {31'h0, int_out});
    service();
    rd_chk("int stat both", IDX_INT_STAT, 32'h3);
    axi_wr(IDX_INT_STAT, 32'h1, RESP_OKAY);
    rd_chk("int stat cleared", IDX_INT_STAT, 32'h2);
    check_val("int after clear", 32'h0, {31'h0, int_out});
    axi_wr(IDX_INT_MASK, 32'h3, RESP_OKAY);
    check_val("int serviced", 32'h1, {31'h0, int_out});
    axi_wr(IDX_INT_STAT, 32'h2, RESP_OKAY);
    check_val("int idle", 32'h0, {31'h0, int_out});
    $display("Test interrupt done");
    print_verdict();
  end
endmodule

// [src/smets_edge.sv]
// Rising and falling edge detector for synchronous level inputs
`timescale 1ns/10ps
module smets_edge
  import smets_pkg::*;
#(
  parameter int W = 2
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] level,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);

  typedef struct packed {
    logic [W-1:0] prev;
    logic primed;
  } smets_edge_state_type;

  smets_edge_state_type s;
  smets_edge_state_type n;

  // ----------------------------------------------------------------
  // Edge logic
  // ----------------------------------------------------------------
  // Primed bit stops a level already high at reset looking like an edge
  always_comb begin
    n = s;
    n.prev = level;
    n.primed = 1'b1;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  // Edges against the previous sample
  assign rise = s.primed ? (level & ~s.prev) : '0;
  assign fall = s.primed ? (~level & s.prev) : '0;

endmodule

// [src/smets_pkg.sv]
// Constants, field positions and carrier types of the management-interrupt event block
package smets_pkg;

  // ----------------------------------------------------------------
  // Clock
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_TRIG_SEL = 8'h33;
  localparam logic [7:0] IDX_TRAP_SEL = 8'h34;
  localparam logic [7:0] IDX_STATUS = 8'h35;
  localparam logic [7:0] IDX_IRQ_GRP = 8'h36;
  localparam logic [7:0] IDX_INT_STAT = 8'h40;
  localparam logic [7:0] IDX_INT_MASK = 8'h41;
  localparam logic [7:0] IDX_CONTROL = 8'h42;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int TRAP_SW_RISE_BIT = 5;
  localparam int TRAP_SW_FALL_BIT = 6;
  localparam int TRAP_DOUBLE_BIT = 7;
  localparam int TRIG_SWITCH_BIT = 7;
  localparam int STATUS_SEL_LSB = 4;
  localparam int CTRL_SW_SMI_BIT = 0;
  localparam int CTRL_DONE_BIT = 1;
  localparam int INT_RAISED_BIT = 0;
  localparam int INT_SERVICED_BIT = 1;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] IRQ_GRP_WMASK = 8'hE5;
  localparam logic [7:0] INT_WMASK = 8'h03;

  // ----------------------------------------------------------------
  // Cause codes and signalling selections
  // ----------------------------------------------------------------
  localparam logic [3:0] CAUSE_NONE = 4'h0;
  localparam logic [3:0] CAUSE_SWITCH = 4'h8;
  localparam logic [3:0] CAUSE_VIDEO = 4'h9;
  localparam logic [3:0] CAUSE_SOFTWARE = 4'hE;
  localparam logic [3:0] CAUSE_TURBO = 4'hF;
  localparam int NUM_CAUSES = 15;
  localparam logic [1:0] CONV_ACTIVE_LOW = 2'h1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    OUT_SMI,
    OUT_NMI,
    OUT_IRQ15,
    OUT_IRQ10
  } smets_outsel_type;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic mode_timer;
    logic input_timer;
    logic gmem_timer;
    logic rtc_alarm;
    logic input_activity;
    logic drq_activity;
    logic [4:0] trap_access;
    logic turbo_status;
  } smets_events_type;

  typedef struct packed {
    logic [7:0] trig_sel;
    logic [7:0] trap_sel;
    logic [3:0] sig_sel;
    logic [7:0] irq_grp;
    logic [7:0] int_stat;
    logic [7:0] int_mask;
  } smets_regs_type;

endpackage

// [src/smets_prio.sv]
// Lowest-numbered pending cause selector
`timescale 1ns/10ps
module smets_prio
  import smets_pkg::*;
#(
  parameter int W = 15
) (
  input wire logic [W-1:0] req,
  output logic [3:0] code,
  output logic [W-1:0] onehot,
  output logic any
);

  // ----------------------------------------------------------------
  // Priority search
  // ----------------------------------------------------------------
  // Bit k stands for cause code k+1; lowest code wins
  always_comb begin
    code = CAUSE_NONE;
    onehot = '0;
    any = 1'b0;
    for (int i = W - 1; i >= 0; i--) begin
      if (req[i]) begin
        code = 4'(i + 1);
        onehot = '0;
        onehot[i] = 1'b1;
        any = 1'b1;
      end
    end
  end

endmodule

// [src/smets_top.sv]
// Management-interrupt event trap, cause status and request routing with AXI4-Lite registers
// What this block does
// R1: Five trap bits enable access-class traps
// R2: Bit 5 traps switch low-to-high edge
// R3: Bit 6 traps switch high-to-low edge
// R4: Trap bit 7 doubles idle timer base
// R5: Read-only cause field, zero means none
// R6: Codes one to seven: timers, alarm, activity
// R7: Codes eight to thirteen: switch, traps
// R8: Code 14 software, 15 turbo transition
// R9: Bits 5:4 route request to output
// R10: Bits 7:6 pick signalling convention
// R11: Status and selection register resets zero
// R12: Group register picks IRQ0, NMI, IRQ5-7
// R13: IRQ1, 3, 4, 12 never counted
// R14: Trap classes: video, disk, printer, ranges
// R15: Codes one to eight fire only when trigger-enabled
// R16: Lowest pending cause held until serviced
`timescale 1ns/10ps
module smets_top
  import smets_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire smets_events_type events,
  input wire logic [15:0] irq_lines,
  input wire logic nmi_in,
  input wire logic suspend_switch_input,
  output logic sys_mgmt_irq,
  output logic nmi_req,
  output logic irq15_req,
  output logic irq10_req,
  output logic double_time_base,
  output logic int_out
);

  typedef struct packed {
    logic aw_held;
    logic w_held;
    logic [7:0] aw_idx;
    logic [7:0] wdata;
    logic wbyte;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    smets_regs_type regs;
    logic [3:0] cause;
    logic [NUM_CAUSES-1:0] pending;
    logic sys_mgmt_irq;
    logic nmi_req;
    logic irq15_req;
    logic irq10_req;
    logic int_out;
  } smets_state_type;

  smets_state_type s;
  smets_state_type n;

  // ----------------------------------------------------------------
  // Register decode helpers
  // ----------------------------------------------------------------
  function automatic logic reg_hit(input logic [7:0] idx);
    case (idx)
      IDX_TRIG_SEL, IDX_TRAP_SEL, IDX_STATUS, IDX_IRQ_GRP,
      IDX_INT_STAT, IDX_INT_MASK, IDX_CONTROL: reg_hit = 1'b1;
      default: reg_hit = 1'b0;
    endcase
  endfunction

  // Control register is write-only strobes and reads as zero
  function automatic logic [7:0] reg_read(input logic [7:0] idx, input smets_regs_type r,
                                          input logic [3:0] cause);
    case (idx)
      IDX_TRIG_SEL: reg_read = r.trig_sel;
      IDX_TRAP_SEL: reg_read = r.trap_sel;
      IDX_STATUS: reg_read = {r.sig_sel, cause}; // [R5]
      IDX_IRQ_GRP: reg_read = r.irq_grp;
      IDX_INT_STAT: reg_read = r.int_stat;
      IDX_INT_MASK: reg_read = r.int_mask;
      default: reg_read = REG_RESET;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Event sources
  // ----------------------------------------------------------------
  logic [1:0] edge_rise;
  logic [1:0] edge_fall;
  logic irq_act;
  logic wr_fire;
  logic sw_smi_w;
  logic done_w;
  logic [NUM_CAUSES-1:0] req_now;
  logic [NUM_CAUSES-1:0] pend_all;
  logic [3:0] prio_code;
  logic [NUM_CAUSES-1:0] prio_onehot;
  logic prio_any;
  smets_outsel_type out_sel;

  smets_edge #(
    .W(2)
  ) u_edge (
    .aclk(aclk),
    .aresetn(aresetn),
    .level({events.turbo_status, suspend_switch_input}),
    .rise(edge_rise),
    .fall(edge_fall)
  );

  // Group activity; only the selectable channels are wired in at all
  assign irq_act = |(s.regs.irq_grp & {irq_lines[7:5], 2'b00, nmi_in, 1'b0, irq_lines[0]}); // [R12] [R13]

  // Control strobes come from the held write, so no loop through the next-state logic
  assign wr_fire = s.aw_held && s.w_held && !s.bvalid && s.wbyte;
  assign sw_smi_w = wr_fire && (s.aw_idx == IDX_CONTROL) && s.wdata[CTRL_SW_SMI_BIT];
  assign done_w = wr_fire && (s.aw_idx == IDX_CONTROL) && s.wdata[CTRL_DONE_BIT];

  // Bit k carries cause code k+1
  assign req_now[0] = events.mode_timer && s.regs.trig_sel[0]; // [R6] [R15]
  assign req_now[1] = events.input_timer && s.regs.trig_sel[1]; // [R6] [R15]
  assign req_now[2] = events.gmem_timer && s.regs.trig_sel[2]; // [R6] [R15]
  assign req_now[3] = events.rtc_alarm && s.regs.trig_sel[3]; // [R6] [R15]
  assign req_now[4] = events.input_activity && s.regs.trig_sel[4]; // [R6] [R15]
  assign req_now[5] = irq_act && s.regs.trig_sel[5]; // [R6] [R15]
  assign req_now[6] = events.drq_activity && s.regs.trig_sel[6]; // [R6] [R15]
  assign req_now[7] = s.regs.trig_sel[TRIG_SWITCH_BIT] &&
                      ((edge_rise[0] && s.regs.trap_sel[TRAP_SW_RISE_BIT]) || // [R2] [R15]
                       (edge_fall[0] && s.regs.trap_sel[TRAP_SW_FALL_BIT])); // [R3] [R7]
  // Video, disk, printer, I/O range, memory range in that order
  assign req_now[12:8] = events.trap_access & s.regs.trap_sel[4:0]; // [R1] [R7] [R14]
  assign req_now[13] = sw_smi_w; // [R8]
  assign req_now[14] = edge_rise[1] || edge_fall[1]; // [R8]
  assign pend_all = s.pending | req_now;

  smets_prio #(
    .W(NUM_CAUSES)
  ) u_prio (
    .req(pend_all),
    .code(prio_code),
    .onehot(prio_onehot),
    .any(prio_any)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [7:0] int_set;
    logic [7:0] int_clr;
    logic act;
    n = s;
    int_set = '0;
    int_clr = '0;
    act = 1'b0;
    // Write channels, taken in either order
    if (s_axi_awvalid && s.awready) begin
      n.aw_held = 1'b1;
      n.aw_idx = s_axi_awaddr[9:2];
    end
    if (s_axi_wvalid && s.wready) begin
      n.w_held = 1'b1;
      n.wdata = s_axi_wdata[7:0];
      n.wbyte = s_axi_wstrb[0];
    end
    if (s.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    if (s.aw_held && s.w_held && !s.bvalid) begin
      n.aw_held = 1'b0;
      n.w_held = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = reg_hit(s.aw_idx) ? RESP_OKAY : RESP_SLVERR;
      if (s.wbyte) begin
        case (s.aw_idx)
          IDX_TRIG_SEL: n.regs.trig_sel = s.wdata;
          IDX_TRAP_SEL: n.regs.trap_sel = s.wdata;
          // Cause nibble is read-only, writes land on the selection bits only
          IDX_STATUS: n.regs.sig_sel = s.wdata[7:STATUS_SEL_LSB]; // [R5] [R9] [R10]
          IDX_IRQ_GRP: n.regs.irq_grp = s.wdata & IRQ_GRP_WMASK; // [R12]
          IDX_INT_STAT: int_clr = s.wdata;
          IDX_INT_MASK: n.regs.int_mask = s.wdata & INT_WMASK;
          default: ;
        endcase
      end
    end
    // Read channel
    if (s.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s.arready) begin
      n.rvalid = 1'b1;
      n.rresp = reg_hit(s_axi_araddr[9:2]) ? RESP_OKAY : RESP_SLVERR;
      n.rdata = {24'h00_0000, reg_read(s_axi_araddr[9:2], s.regs, s.cause)};
    end
    n.awready = !n.aw_held && !n.bvalid;
    n.wready = !n.w_held && !n.bvalid;
    n.arready = !n.rvalid;
    // Cause capture; later events wait in pending so none is dropped
    n.pending = pend_all;
    if (done_w) begin
      n.cause = CAUSE_NONE;
      int_set[INT_SERVICED_BIT] = 1'b1;
    end
    // A new cause taken in the service cycle wins over the clear
    if ((s.cause == CAUSE_NONE || done_w) && prio_any) begin
      n.cause = prio_code; // [R16]
      n.pending = pend_all & ~prio_onehot; // [R16]
      int_set[INT_RAISED_BIT] = 1'b1;
    end
    // Sticky status: set beats a same-cycle write-one clear
    n.regs.int_stat = ((s.regs.int_stat & ~int_clr) | int_set) & INT_WMASK;
    n.int_out = |(n.regs.int_stat & n.regs.int_mask);
    // Routing and polarity of the request
    act = (n.cause != CAUSE_NONE);
    n.nmi_req = act && (n.regs.sig_sel[1:0] == OUT_NMI); // [R9]
    n.irq15_req = act && (n.regs.sig_sel[1:0] == OUT_IRQ15); // [R9]
    n.irq10_req = act && (n.regs.sig_sel[1:0] == OUT_IRQ10); // [R9]
    // Reserved convention code behaves like the first one
    n.sys_mgmt_irq = (act && (n.regs.sig_sel[1:0] == OUT_SMI)) ^
                     (n.regs.sig_sel[3:2] == CONV_ACTIVE_LOW); // [R9] [R10]
  end

  // State register; all-zero reset clears status and selection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0; // [R11]
    end else begin
      s <= n;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign out_sel = smets_outsel_type'(s.regs.sig_sel[1:0]);
  assign s_axi_awready = s.awready;
  assign s_axi_wready = s.wready;
  assign s_axi_bresp = s.bresp;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_arready = s.arready;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;
  assign s_axi_rvalid = s.rvalid;
  assign sys_mgmt_irq = s.sys_mgmt_irq;
  assign nmi_req = s.nmi_req;
  assign irq15_req = s.irq15_req;
  assign irq10_req = s.irq10_req;
  assign double_time_base = s.regs.trap_sel[TRAP_DOUBLE_BIT]; // [R4]
  assign int_out = s.int_out;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_cause_lowest;
    (s.cause == CAUSE_NONE && prio_any) |=> (s.cause == $past(prio_code)) && (s.cause != 4'h0);
  endproperty
  a_cause_lowest: assert property (p_cause_lowest) else $error("cause not lowest pending"); // [R16]

  property p_cause_hold;
    (s.cause != CAUSE_NONE && !done_w) |=> $stable(s.cause);
  endproperty
  a_cause_hold: assert property (p_cause_hold) else $error("cause changed before service"); // [R16]

  property p_sw_rise;
    (edge_rise[0] && s.regs.trig_sel[7] && s.regs.trap_sel[5])
      |=> (s.pending[7] || s.cause == CAUSE_SWITCH);
  endproperty
  a_sw_rise: assert property (p_sw_rise) else $error("switch rise not trapped"); // [R2]

  property p_sw_fall;
    (edge_fall[0] && s.regs.trig_sel[7] && s.regs.trap_sel[6])
      |=> (s.pending[7] || s.cause == CAUSE_SWITCH);
  endproperty
  a_sw_fall: assert property (p_sw_fall) else $error("switch fall not trapped"); // [R3]

  property p_sw_disabled;
    (!s.regs.trig_sel[7] && !s.pending[7]) |=> !s.pending[7];
  endproperty
  a_sw_disabled: assert property (p_sw_disabled) else $error("switch pending while off"); // [R15]

  property p_trap_disabled;
    (!s.regs.trap_sel[0] && !s.pending[8] && s.cause != CAUSE_VIDEO)
      |=> (s.cause != CAUSE_VIDEO);
  endproperty
  a_trap_disabled: assert property (p_trap_disabled) else $error("disabled trap fired"); // [R1]

  property p_double;
    $rose(double_time_base) |-> $past(wr_fire && s.aw_idx == IDX_TRAP_SEL && s.wdata[7]);
  endproperty
  a_double: assert property (p_double) else $error("time base doubled without write"); // [R4]

  // A register write may move the route or end the cause, so only quiet cycles count
  property p_route;
    (s.cause != CAUSE_NONE && out_sel == OUT_IRQ15 && !wr_fire)
      |=> irq15_req && !nmi_req && !irq10_req;
  endproperty
  a_route: assert property (p_route) else $error("request on wrong output"); // [R9]

  property p_conv_low;
    (s.cause == CAUSE_NONE && s.regs.sig_sel[3:2] == CONV_ACTIVE_LOW && !prio_any && !wr_fire)
      |=> sys_mgmt_irq;
  endproperty
  a_conv_low: assert property (p_conv_low) else $error("idle level wrong for low convention"); // [R10]

  property p_irq_excluded;
    ((irq_lines[7:5] == 3'h0) && !irq_lines[0] && !nmi_in) |-> !irq_act;
  endproperty
  a_irq_excluded: assert property (p_irq_excluded) else $error("excluded irq counted"); // [R13]

  property p_reset_zero;
    $rose(aresetn) |-> (s.cause == CAUSE_NONE) && (s.regs.sig_sel == 4'h0);
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("status not zero after reset"); // [R11]

  c_switch: cover property (s.cause == CAUSE_SWITCH);
  c_trap: cover property (s.cause == CAUSE_VIDEO);
  c_software: cover property (s.cause == CAUSE_SOFTWARE ##1 done_w);
  c_nmi: cover property (nmi_req);

endmodule
